/* File: rtl/scq_regs.svh */
// Constants of the system command and error queue block
`ifndef SCQ_REGS_SVH
`define SCQ_REGS_SVH
// Error numbers, 16-bit two's complement
`define SCQ_ERR_NONE   16'h0000
`define SCQ_ERR_CMD    16'hff9c
`define SCQ_ERR_MISS   16'hff93
`define SCQ_ERR_LONG   16'hff90
`define SCQ_ERR_RANGE  16'hff88
`define SCQ_ERR_CONF   16'hff23
`define SCQ_ERR_MUCH   16'hff21
`define SCQ_ERR_OVF    16'hfea2
// Argument limits
`define SCQ_MNEM_MAX   6'h0c
`define SCQ_CMDS_MAX   4'h8
`define SCQ_SLOT_MIN   8'h01
`define SCQ_SLOT_MAX   8'h0a
`define SCQ_SLOTS      10
`define SCQ_IF_ONE     8'h01
`define SCQ_IF_TWO     8'h02
// Error queue depth and pointer width
`define SCQ_EQ_DEPTH   8
`define SCQ_EQ_AW      3
// Execution time in ms, clock in MHz, kHz per MHz
`define SCQ_EXEC_MS    250
`define SCQ_CLK_MHZ    250
`define SCQ_KHZ_PER_MHZ 1000
// Text answers and characters
`define SCQ_TEXT_W     384
`define SCQ_ASC_0      8'h30
`define SCQ_ASC_A10    8'h37
`define SCQ_ASC_SP     8'h20
`define SCQ_ASC_NUL    8'h00
`endif

/* File: rtl/scq_pkg.sv */
// Types of the system command and error queue block
`include "scq_regs.svh"
package scq_pkg;
  // Decoded command kinds
  typedef enum logic [3:0] {
    SCQ_OP_REMOTE  = 4'h0,
    SCQ_OP_ERR_Q   = 4'h1,
    SCQ_OP_VER_Q   = 4'h2,
    SCQ_OP_LOCAL   = 4'h3,
    SCQ_OP_CODE_Q  = 4'h4,
    SCQ_OP_IFSEL   = 4'h5,
    SCQ_OP_STORE   = 4'h6,
    SCQ_OP_STORE_Q = 4'h7,
    SCQ_OP_OTHER   = 4'hf
  } scq_cmd_t;
  // Sequencer, Gray along idle, busy, drain
  typedef enum logic [1:0] {
    SCQ_IDLE  = 2'h0,
    SCQ_BUSY  = 2'h1,
    SCQ_DRAIN = 2'h3
  } scq_state_t;
  typedef logic [`SCQ_TEXT_W-1:0] scq_text_t;
  typedef struct packed {
    scq_state_t                      state;
    logic                            remote;
    logic                            iface;
    logic                            halt;
    logic [2:0]                      rd_sync;
    logic                            bus_read;
    logic                            rsp_pend;
    logic                            rsp_err;
    logic [15:0]                     rsp_code;
    scq_text_t                       rsp_text;
    logic [31:0]                     rsp_cfg;
    logic [`SCQ_SLOTS-1:0][31:0]     slot_cfg;
    logic [`SCQ_SLOTS-1:0][63:0]     slot_name;
  } scq_top_st_t;
  typedef struct packed {
    logic [`SCQ_EQ_DEPTH-1:0][15:0]  mem;
    logic [`SCQ_EQ_AW-1:0]           rd;
    logic [`SCQ_EQ_AW-1:0]           wr;
    logic [`SCQ_EQ_AW:0]             cnt;
  } scq_fifo_st_t;
  typedef struct packed {
    logic [31:0]                     cnt;
  } scq_tmr_st_t;
endpackage

/* File: rtl/scq_eq_if.sv */
// Link between the command sequencer and its error queue
`timescale 1ns/1ps
interface scq_eq_if;
  logic        push;
  logic [15:0] push_code;
  logic        pop;
  logic [15:0] head;
  logic        empty;
  modport cmd   (output push, push_code, pop, input head, empty);
  modport queue (input push, push_code, pop, output head, empty);
endinterface

/* File: rtl/scq_err_fifo.sv */
// First-in first-out error queue with overflow marker
`timescale 1ns/1ps
`include "scq_regs.svh"
module scq_err_fifo (
  // Clock and reset
  input  logic          clk,
  input  logic          rst,
  // Sequencer side
  scq_eq_if.queue       q
);
  scq_pkg::scq_fifo_st_t s;
  scq_pkg::scq_fifo_st_t next_s;
  localparam logic [`SCQ_EQ_AW:0] LAST = (`SCQ_EQ_AW+1)'(`SCQ_EQ_DEPTH - 1);

  // Push wins over pop; the sequencer never asks for both at once
  always_comb
  begin
    next_s = s;
    if (q.push)
    begin
      if (s.cnt < LAST)
      begin
        next_s.mem[s.wr] = q.push_code;
        next_s.wr        = s.wr + 1'b1;
        next_s.cnt       = s.cnt + 1'b1;
      end
      else if (s.cnt == LAST)
      begin
        next_s.mem[s.wr] = `SCQ_ERR_OVF;
        next_s.wr        = s.wr + 1'b1;
        next_s.cnt       = s.cnt + 1'b1;
      end
      // Full: oldest kept, newest already holds the marker
    end
    else if (q.pop && s.cnt != '0)
    begin
      next_s.rd  = s.rd + 1'b1;
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  // Empty queue answers zero
  assign q.empty = (s.cnt == '0);
  assign q.head  = q.empty ? `SCQ_ERR_NONE : s.mem[s.rd];

  ////////////////////////////////////////////////////////////////////////////
  // Entry that becomes the head after one pop, seen by the order check
  logic [15:0] after_head;
  assign after_head = s.mem[s.rd + 1'b1];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_fill_marks;
    q.push && s.cnt == LAST |=> s.mem[s.wr - 1'b1] == `SCQ_ERR_OVF
      && s.cnt == LAST + 1'b1;
  endproperty
  a_fill_marks: assert property (p_fill_marks)
    else $error("Overflow marker missing when queue filled");

  property p_full_keeps;
    q.push && s.cnt > LAST |=> $stable(s.mem) && $stable(s.cnt);
  endproperty
  a_full_keeps: assert property (p_full_keeps)
    else $error("Full queue changed on push");

  property p_fifo_order;
    q.pop && !q.push && s.cnt > 1 |=> q.head == $past(after_head);
  endproperty
  a_fifo_order: assert property (p_fifo_order)
    else $error("Queue did not advance to next oldest entry");

  c_overflow: cover property (q.push && s.cnt == LAST);
endmodule // scq_err_fifo

/* File: rtl/scq_busy_timer.sv */
// Hold-off timer that spaces command execution
`timescale 1ns/1ps
module scq_busy_timer #(
  parameter int unsigned CYCLES = 1
)(
  // Clock and reset
  input  logic clk,
  input  logic rst,
  // Control
  input  logic start,
  output logic busy
);
  scq_pkg::scq_tmr_st_t s;
  scq_pkg::scq_tmr_st_t next_s;

  // Load on start, count down to zero
  always_comb
  begin
    next_s = s;
    if (start)
      next_s.cnt = 32'(CYCLES - 1);
    else if (s.cnt != 32'h0000_0000)
      next_s.cnt = s.cnt - 32'h0000_0001;
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign busy = (s.cnt != 32'h0000_0000);
endmodule // scq_busy_timer

/* File: rtl/scq_top.sv */
// System command sequencer with error queue and configuration slots
//
// Summary of operation
// - Enter-remote acted on only from local mode
// - Enter-remote halts test, keeps configuration
// - Error query pops oldest entry, empty gives 0
// - Version query returns language revision level
// - Return-to-local restores front-panel operation
// - Code query returns 24-char hex string, NUL-terminated
// - Local interface select picks bus variant
// - Local store saves configuration to slot 1-10
// - Optional name replaces default mode title
// - Remote store query returns slot name
// - Store query carries no name argument
// - Bad or failing commands queue an error
// - Error answer is number plus message
// - Codes -100 syntax, -109 missing, 0 none
// - Code -112 for mnemonic over 12
// - Code -120 for out-of-range number
// - Code -221 for setting conflict
// - Code -223 for too many commands
// - Full queue records -350 overflow
// - Each command takes at least 250 ms
// - Serial link answers without read request
`timescale 1ns/1ps
`include "scq_regs.svh"
module scq_top #(
  parameter int unsigned EXEC_CYCLES =
    `SCQ_EXEC_MS * `SCQ_CLK_MHZ * `SCQ_KHZ_PER_MHZ,
  parameter scq_pkg::scq_text_t VERSION_TEXT = scq_pkg::scq_text_t'("0.0")
)(
  // Clock and reset
  input  logic                CLOCK,
  input  logic                RST,
  // Decoded command in
  input  logic                CMD_VALID,
  output logic                CMD_READY,
  input  scq_pkg::scq_cmd_t   CMD_OP,
  input  logic                CMD_BAD_SYNTAX,
  input  logic [5:0]          CMD_MNEM_LEN,
  input  logic [3:0]          CMD_COUNT,
  input  logic                CMD_ARG_PRESENT,
  input  logic [7:0]          CMD_ARG,
  input  logic                CMD_NAME_PRESENT,
  input  logic [63:0]         CMD_NAME,
  // Instrument state
  input  logic [31:0]         CFG_CURRENT,
  input  logic [63:0]         MODE_TITLE,
  input  logic [63:0]         CFG_CODE,
  input  logic                SERIAL_SEL,
  input  logic                BUS_READ,
  // Mode outputs
  output logic                REMOTE,
  output logic                TEST_HALT,
  output logic                IFACE_SEL,
  // Answer out
  output logic                RSP_VALID,
  input  logic                RSP_READY,
  output logic                RSP_IS_ERR,
  output logic [15:0]         RSP_CODE,
  output scq_pkg::scq_text_t  RSP_TEXT,
  output logic [31:0]         RSP_CFG
);
  scq_pkg::scq_top_st_t s;
  scq_pkg::scq_top_st_t next_s;
  scq_eq_if             eq ();
  logic                 tmr_start;
  logic                 tmr_busy;
  logic                 take;
  logic                 lex_ok;
  logic                 rsp_fire;

  ////////////////////////////////////////////////////////////////////////////
  // Message text for each error number
  function automatic scq_pkg::scq_text_t msg_of(input logic [15:0] c);
    case (c)
      `SCQ_ERR_NONE:  return scq_pkg::scq_text_t'("No error.");
      `SCQ_ERR_CMD:   return scq_pkg::scq_text_t'("Command error.");
      `SCQ_ERR_MISS:  return scq_pkg::scq_text_t'("Missing parameter.");
      `SCQ_ERR_LONG:
        return scq_pkg::scq_text_t'("Parameter mnemonic too long.");
      `SCQ_ERR_RANGE: return scq_pkg::scq_text_t'("Numeric data error.");
      `SCQ_ERR_CONF:  return scq_pkg::scq_text_t'("Setting conflict.");
      `SCQ_ERR_MUCH:  return scq_pkg::scq_text_t'("Too much data.");
      `SCQ_ERR_OVF:   return scq_pkg::scq_text_t'("Queue overflow.");
      default:        return scq_pkg::scq_text_t'("Unknown error.");
    endcase
  endfunction

  // One nibble as an upper-case hex character
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    if (n < 4'ha)
      return 8'({4'h0, n} + `SCQ_ASC_0);
    return 8'({4'h0, n} + `SCQ_ASC_A10);
  endfunction

  // Eight bytes as "hh hh ... hh" plus terminator, 24 characters
  function automatic scq_pkg::scq_text_t code_str(input logic [63:0] v);
    scq_pkg::scq_text_t t;
    t = '0;
    for (int i = 0; i < 8; i++)
    begin
      t[191 - 24*i -: 8] = hex_ch(v[63 - 8*i -: 4]);
      t[183 - 24*i -: 8] = hex_ch(v[59 - 8*i -: 4]);
      t[175 - 24*i -: 8] = (i == 7) ? `SCQ_ASC_NUL : `SCQ_ASC_SP;
    end
    return t;
  endfunction

  // Slot number in range
  function automatic logic slot_ok(input logic [7:0] n);
    return n >= `SCQ_SLOT_MIN && n <= `SCQ_SLOT_MAX;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes
  assign take      = CMD_VALID && CMD_READY;
  assign CMD_READY = (s.state == scq_pkg::SCQ_IDLE);
  // Bus answers wait for a read request; serial goes out at once
  assign RSP_VALID = s.rsp_pend && (SERIAL_SEL || s.bus_read);
  assign rsp_fire  = RSP_VALID && RSP_READY;
  // Checks that apply to every command before its meaning
  assign lex_ok    = !CMD_BAD_SYNTAX && CMD_MNEM_LEN <= `SCQ_MNEM_MAX
                     && CMD_COUNT <= `SCQ_CMDS_MAX;

  // Next state: sequencer, mode, slots and the answer register
  always_comb
  begin
    logic [15:0] err;
    logic [3:0]  idx;
    next_s       = s;
    err          = `SCQ_ERR_NONE;
    idx          = 4'(CMD_ARG - `SCQ_SLOT_MIN);
    eq.pop       = 1'b0;
    tmr_start    = 1'b0;
    next_s.halt  = 1'b0;
    // Three-stage pin sampling, change accepted when last two agree
    next_s.rd_sync = {s.rd_sync[1:0], BUS_READ};
    if (s.rd_sync[1] == s.rd_sync[2])
      next_s.bus_read = s.rd_sync[2];
    if (rsp_fire)
      next_s.rsp_pend = 1'b0;
    case (s.state)
      scq_pkg::SCQ_IDLE:
      begin
        if (take)
        begin
          tmr_start    = 1'b1;
          next_s.state = scq_pkg::SCQ_BUSY;
          if (CMD_BAD_SYNTAX)
            err = `SCQ_ERR_CMD;
          else if (CMD_MNEM_LEN > `SCQ_MNEM_MAX)
            err = `SCQ_ERR_LONG;
          else if (CMD_COUNT > `SCQ_CMDS_MAX)
            err = `SCQ_ERR_MUCH;
          else
          begin
            case (CMD_OP)
              scq_pkg::SCQ_OP_REMOTE:
                if (s.remote)
                  err = `SCQ_ERR_CONF;
                else
                begin
                  next_s.remote = 1'b1;
                  next_s.halt   = 1'b1;
                end
              scq_pkg::SCQ_OP_LOCAL:
                next_s.remote = 1'b0;
              scq_pkg::SCQ_OP_ERR_Q:
              begin
                eq.pop          = 1'b1;
                next_s.rsp_pend = 1'b1;
                next_s.rsp_err  = 1'b1;
                next_s.rsp_code = eq.head;
                next_s.rsp_text = msg_of(eq.head);
              end
              scq_pkg::SCQ_OP_VER_Q:
              begin
                next_s.rsp_pend = 1'b1;
                next_s.rsp_err  = 1'b0;
                next_s.rsp_code = `SCQ_ERR_NONE;
                next_s.rsp_text = VERSION_TEXT;
              end
              scq_pkg::SCQ_OP_CODE_Q:
              begin
                next_s.rsp_pend = 1'b1;
                next_s.rsp_err  = 1'b0;
                next_s.rsp_code = `SCQ_ERR_NONE;
                next_s.rsp_text = code_str(CFG_CODE);
              end
              scq_pkg::SCQ_OP_IFSEL:
                if (s.remote)
                  err = `SCQ_ERR_CONF;
                else if (!CMD_ARG_PRESENT)
                  err = `SCQ_ERR_MISS;
                else if (CMD_ARG == `SCQ_IF_ONE)
                  next_s.iface = 1'b0;
                else if (CMD_ARG == `SCQ_IF_TWO)
                  next_s.iface = 1'b1;
                else
                  err = `SCQ_ERR_RANGE;
              scq_pkg::SCQ_OP_STORE:
                if (s.remote)
                  err = `SCQ_ERR_CONF;
                else if (!CMD_ARG_PRESENT)
                  err = `SCQ_ERR_MISS;
                else if (!slot_ok(CMD_ARG))
                  err = `SCQ_ERR_RANGE;
                else
                begin
                  // Saved mode is whatever runs now, set up locally
                  next_s.slot_cfg[idx]  = CFG_CURRENT;
                  next_s.slot_name[idx] = CMD_NAME_PRESENT
                                          ? CMD_NAME
                                          : MODE_TITLE;
                end
              scq_pkg::SCQ_OP_STORE_Q:
                if (!s.remote)
                  err = `SCQ_ERR_CONF;
                else if (CMD_NAME_PRESENT)
                  err = `SCQ_ERR_CMD;
                else if (!CMD_ARG_PRESENT)
                  err = `SCQ_ERR_MISS;
                else if (!slot_ok(CMD_ARG))
                  err = `SCQ_ERR_RANGE;
                else
                begin
                  next_s.rsp_pend = 1'b1;
                  next_s.rsp_err  = 1'b0;
                  next_s.rsp_code = `SCQ_ERR_NONE;
                  next_s.rsp_text = scq_pkg::scq_text_t'(
                                      s.slot_name[idx]);
                  next_s.rsp_cfg  = s.slot_cfg[idx];
                end
              default:
                ;
            endcase
          end
        end
      end
      scq_pkg::SCQ_BUSY:
        if (!tmr_busy)
          next_s.state = next_s.rsp_pend ? scq_pkg::SCQ_DRAIN
                                         : scq_pkg::SCQ_IDLE;
      scq_pkg::SCQ_DRAIN:
        if (!next_s.rsp_pend)
          next_s.state = scq_pkg::SCQ_IDLE;
      default:
        next_s.state = scq_pkg::SCQ_IDLE;
    endcase
    eq.push      = (err != `SCQ_ERR_NONE);
    eq.push_code = err;
  end

  // State register
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      s <= '0;
    else
      s <= next_s;
  end

  // Outputs straight from the state register
  assign REMOTE     = s.remote;
  assign TEST_HALT  = s.halt;
  assign IFACE_SEL  = s.iface;
  assign RSP_IS_ERR = s.rsp_err;
  assign RSP_CODE   = s.rsp_code;
  assign RSP_TEXT   = s.rsp_text;
  assign RSP_CFG    = s.rsp_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Error queue and hold-off timer
  scq_err_fifo u_fifo (
    .clk (CLOCK),
    .rst (RST),
    .q   (eq.queue)
  );

  scq_busy_timer #(
    .CYCLES (EXEC_CYCLES)
  ) u_tmr (
    .clk   (CLOCK),
    .rst   (RST),
    .start (tmr_start),
    .busy  (tmr_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last accepted command, for checking only
  logic [31:0] since_take;
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      since_take <= 32'h0000_0000;
    else if (take)
      since_take <= 32'h0000_0001;
    else if (since_take != 32'hffff_ffff)
      since_take <= since_take + 32'h0000_0001;
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  property p_remote_from_local;
    TEST_HALT |-> !$past(s.remote) && REMOTE;
  endproperty
  a_remote_from_local: assert property (p_remote_from_local)
    else $error("Halt pulse without a local to remote change");

  property p_remote_entry;
    take && lex_ok && CMD_OP == scq_pkg::SCQ_OP_REMOTE && !s.remote
      |=> REMOTE && TEST_HALT && $stable(s.slot_cfg) && $stable(IFACE_SEL);
  endproperty
  a_remote_entry: assert property (p_remote_entry)
    else $error("Remote entry did not halt or changed settings");

  property p_local_return;
    take && lex_ok && CMD_OP == scq_pkg::SCQ_OP_LOCAL |=> !REMOTE;
  endproperty
  a_local_return: assert property (p_local_return)
    else $error("Return to local left remote mode set");

  property p_empty_zero;
    take && lex_ok && CMD_OP == scq_pkg::SCQ_OP_ERR_Q && eq.empty
      |=> RSP_CODE == `SCQ_ERR_NONE && RSP_IS_ERR && s.rsp_pend;
  endproperty
  a_empty_zero: assert property (p_empty_zero)
    else $error("Empty queue query did not answer zero");

  property p_code_string;
    take && lex_ok && CMD_OP == scq_pkg::SCQ_OP_CODE_Q
      |=> RSP_TEXT[7:0] == `SCQ_ASC_NUL && RSP_TEXT[31:24] == `SCQ_ASC_SP
      && RSP_TEXT[191:184] == hex_ch(4'($past(CFG_CODE) >> 60));
  endproperty
  a_code_string: assert property (p_code_string)
    else $error("Configuration code string badly formed");

  property p_iface_two;
    take && lex_ok && !s.remote && CMD_OP == scq_pkg::SCQ_OP_IFSEL
      && CMD_ARG_PRESENT && CMD_ARG == `SCQ_IF_TWO |=> IFACE_SEL;
  endproperty
  a_iface_two: assert property (p_iface_two)
    else $error("Interface select did not adopt second variant");

  property p_store_saves;
    take && lex_ok && !s.remote && CMD_OP == scq_pkg::SCQ_OP_STORE
      && CMD_ARG_PRESENT && slot_ok(CMD_ARG)
      |=> s.slot_cfg[4'($past(CMD_ARG) - `SCQ_SLOT_MIN)] == $past(CFG_CURRENT);
  endproperty
  a_store_saves: assert property (p_store_saves)
    else $error("Store did not save configuration to slot");

  property p_bad_slot;
    take && CMD_OP == scq_pkg::SCQ_OP_STORE && !slot_ok(CMD_ARG)
      |-> eq.push ##1 $stable(s.slot_cfg) && $stable(s.slot_name);
  endproperty
  a_bad_slot: assert property (p_bad_slot)
    else $error("Bad slot number changed slots or raised no error");

  property p_syntax_code;
    take && CMD_BAD_SYNTAX |-> eq.push && eq.push_code == `SCQ_ERR_CMD;
  endproperty
  a_syntax_code: assert property (p_syntax_code)
    else $error("Malformed command not queued as -100");

  property p_exec_time;
    $rose(CMD_READY) |-> since_take >= EXEC_CYCLES + 1;
  endproperty
  a_exec_time: assert property (p_exec_time)
    else $error("Command finished before its execution time");

  property p_serial_now;
    take && lex_ok && CMD_OP == scq_pkg::SCQ_OP_ERR_Q
      |=> !SERIAL_SEL || RSP_VALID;
  endproperty
  a_serial_now: assert property (p_serial_now)
    else $error("Serial answer held back");

  c_remote: cover property (take && CMD_OP == scq_pkg::SCQ_OP_REMOTE
                            && !s.remote);
  c_err_pop: cover property (take && CMD_OP == scq_pkg::SCQ_OP_ERR_Q
                             && !eq.empty);
  c_store_q: cover property (take && CMD_OP == scq_pkg::SCQ_OP_STORE_Q
                             && s.remote ##[1:8] rsp_fire);
endmodule // scq_top

/* File: verification/scq_ctl_model.sv */
// Controller-side answer reader for the system command bench
`timescale 1ns/1ps
module scq_ctl_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Answer handshake
  input  wire logic rsp_valid,
  input  wire logic slow,
  output logic      rsp_ready,
  output logic      bus_read
);
  logic [1:0] dly;
  // Slow mode stalls each answer and stops bus reads, as a busy host would
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dly       <= 2'h0;
      rsp_ready <= 1'b0;
      bus_read  <= 1'b0;
    end
    else
    begin
      dly       <= rsp_valid ? dly + 2'h1 : 2'h0;
      rsp_ready <= rsp_valid && (!slow || dly == 2'h3);
      bus_read  <= !slow;
    end
  end
endmodule // scq_ctl_model

/* File: verification/tb.sv */
// Self-checking bench for the system command sequencer
`timescale 1ns/1ps
`include "scq_regs.svh"
module tb;
  logic               clk, rst, cv, cr, cbad, argp, namep, srl, brd;
  logic               rv, rr, rie, halt, rem, ifs, slow, hs, vs;
  scq_pkg::scq_cmd_t  op;
  logic [5:0]         mlen;
  logic [3:0]         ccnt;
  logic [7:0]         arg, s, s2;
  logic [63:0]        name, title, ccode;
  logic [31:0]        cfg, rcfg;
  logic [15:0]        rcode;
  scq_pkg::scq_text_t rtext;
  int                 miscompares, checked, n;
  logic [15:0]        eq [9];

  scq_top #(.EXEC_CYCLES(20), .VERSION_TEXT(scq_pkg::scq_text_t'("2.5")))
  scq_top_i (.CLOCK(clk), .RST(rst), .CMD_VALID(cv), .CMD_READY(cr),
    .CMD_OP(op), .CMD_BAD_SYNTAX(cbad), .CMD_MNEM_LEN(mlen),
    .CMD_COUNT(ccnt), .CMD_ARG_PRESENT(argp), .CMD_ARG(arg),
    .CMD_NAME_PRESENT(namep), .CMD_NAME(name), .CFG_CURRENT(cfg),
    .MODE_TITLE(title), .CFG_CODE(ccode), .SERIAL_SEL(srl), .BUS_READ(brd),
    .REMOTE(rem), .TEST_HALT(halt), .IFACE_SEL(ifs), .RSP_VALID(rv),
    .RSP_READY(rr), .RSP_IS_ERR(rie), .RSP_CODE(rcode), .RSP_TEXT(rtext),
    .RSP_CFG(rcfg));
  scq_ctl_model scq_ctl_model_i (.clk(clk), .rst(rst), .rsp_valid(rv),
    .slow(slow), .rsp_ready(rr), .bus_read(brd));

  ////////////////////////////////////////////////////////////////////////////
  // Hex text of the configuration code, space separated, NUL at the end
  function automatic logic [191:0] code_str(input logic [63:0] c);
    logic [191:0] t;
    logic [3:0]   d;
    t = '0;
    for (int i = 0; i < 16; i++)
    begin
      d = c[63-4*i -: 4];
      t = {t[183:0], (d < 4'ha) ? 8'h30 + d : 8'h37 + d};
      if (i % 2 == 1)
        t = {t[183:0], (i == 15) ? 8'h00 : 8'h20};
    end
    return t;
  endfunction

  task chk(input logic [191:0] seen, input logic [191:0] exp);
  begin
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask

  task tally_and_finish;
  begin
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  // Offer one command, then wait for the sequencer to free up again
  task cmd(input scq_pkg::scq_cmd_t o, input logic [7:0] a,
           input logic ap, input logic [2:0] f);
  begin
    @(posedge clk);
    cv <= 1'b1;
    op <= o;
    arg <= a;
    argp <= ap;
    namep <= f[2];
    cbad <= (f == 3'h1);
    mlen <= (f == 3'h2) ? 6'h0d : 6'h0c;
    ccnt <= (f == 3'h3) ? 4'h9 : 4'h8;
    @(posedge clk);
    cv <= 1'b0;
    #1;
    hs = halt;
    vs = 1'b0;
    n = 0;
    while (cr !== 1'b1 && n < 300)
    begin
      vs = vs | (rv === 1'b1);
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= 20, 1'b1);
    if (n >= 300)
    begin
      miscompares++;
      tally_and_finish;
    end
  end
  endtask

  task errq(input logic [15:0] e);
  begin
    cmd(scq_pkg::SCQ_OP_ERR_Q, 8'h00, 1'b0, 3'h0);
    chk(rcode, e);
    chk(rie, 1'b1);
    chk(rtext != '0, 1'b1);
    chk(vs, 1'b1);
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Main sequence: local setup and faults, then remote reads
  initial
  begin
    {rst, cv, cbad, argp, namep, srl, slow} = 7'h40;
    {mlen, ccnt, arg} = '0;
    op = scq_pkg::SCQ_OP_OTHER;
    miscompares = 0;
    checked = 0;
    n = $urandom(19405);
    ccode = {$urandom, $urandom};
    title = {$urandom, $urandom};
    name = {$urandom, $urandom};
    cfg = $urandom;
    s = 8'($urandom_range(10, 1));
    s2 = (s == 8'h0a) ? 8'h01 : s + 8'h01;
    eq = '{`SCQ_ERR_RANGE, `SCQ_ERR_RANGE, `SCQ_ERR_RANGE, `SCQ_ERR_MISS,
           `SCQ_ERR_CMD, `SCQ_ERR_LONG, `SCQ_ERR_MUCH, `SCQ_ERR_OVF,
           `SCQ_ERR_NONE};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    errq(`SCQ_ERR_NONE);
    cmd(scq_pkg::SCQ_OP_VER_Q, 8'h00, 1'b0, 3'h0);
    chk(rtext[191:0], {168'h0, "2.5"});
    chk(rie, 1'b0);
    cmd(scq_pkg::SCQ_OP_CODE_Q, 8'h00, 1'b0, 3'h0);
    chk(rtext[191:0], code_str(ccode));
    for (int i = 2; i > 0; i--)
    begin
      cmd(scq_pkg::SCQ_OP_IFSEL, 8'(i), 1'b1, 3'h0);
      chk(ifs, i == 2);
    end
    // Queue fills: 3 range, missing, syntax, long, many, then overflow
    cmd(scq_pkg::SCQ_OP_IFSEL, 8'h03, 1'b1, 3'h0);
    cmd(scq_pkg::SCQ_OP_STORE, s, 1'b1, 3'h4);
    cmd(scq_pkg::SCQ_OP_STORE, s2, 1'b1, 3'h0);
    cmd(scq_pkg::SCQ_OP_STORE, 8'h00, 1'b1, 3'h0);
    cmd(scq_pkg::SCQ_OP_STORE, 8'h0b, 1'b1, 3'h0);
    cmd(scq_pkg::SCQ_OP_STORE, 8'h00, 1'b0, 3'h0);
    for (int f = 1; f < 4; f++)
      cmd(scq_pkg::SCQ_OP_OTHER, 8'h00, 1'b0, 3'(f));
    cmd(scq_pkg::SCQ_OP_STORE_Q, s, 1'b1, 3'h0);
    cmd(scq_pkg::SCQ_OP_OTHER, 8'h00, 1'b0, 3'h1);
    @(posedge clk);
    srl <= 1'b1;
    slow <= 1'b1;
    cmd(scq_pkg::SCQ_OP_REMOTE, 8'h00, 1'b0, 3'h0);
    chk(hs, 1'b1);
    chk(rem, 1'b1);
    foreach (eq[i])
      errq(eq[i]);
    cmd(scq_pkg::SCQ_OP_REMOTE, 8'h00, 1'b0, 3'h0);
    errq(`SCQ_ERR_CONF);
    cmd(scq_pkg::SCQ_OP_STORE_Q, s, 1'b1, 3'h0);
    chk(rtext[63:0], name);
    chk(rcfg, cfg);
    cmd(scq_pkg::SCQ_OP_STORE_Q, s2, 1'b1, 3'h0);
    chk(rtext[63:0], title);
    cmd(scq_pkg::SCQ_OP_STORE_Q, s, 1'b1, 3'h4);
    errq(`SCQ_ERR_CMD);
    cmd(scq_pkg::SCQ_OP_LOCAL, 8'h00, 1'b0, 3'h0);
    chk(rem, 1'b0);
    tally_and_finish;
  end
endmodule // tb
